// ### rtl/eac_cycle_ctrl.sv
// External bus cycle controller for chip-select groups with acknowledge support.
// Assumes requester holds request fields stable until done or error is seen.
// Notes on behaviour
// - Timeout error after 1022 clocks awaiting acknowledge
// - Only group five honours external acknowledge
// - Acknowledge is active low
// - Read strobes delayed by output-enable field
// - Read byte strobes only when control bit clear
// - Read: address and select at first clock
// - Write: select and strobes use delay fields
// - Write: address and write level at first
// - Internal wait states end cycle without acknowledge
// - All bus outputs launched from system clock
// - Read byte control sits at bit 11
`timescale 1ns/1ps
module eac_cycle_ctrl
  import eac_pkg::*;
(
  input  wire logic                        MCLK_IN,
  input  wire logic                        RST_N_IN,
  input  wire logic                        REQ_IN,
  input  wire logic                        REQ_WRITE_IN,
  input  wire logic [eac_pkg::GRP_W-1:0]   REQ_GROUP_IN,
  input  wire logic [eac_pkg::ADDR_W-1:0]  REQ_ADDR_IN,
  input  wire logic [eac_pkg::DATA_W-1:0]  REQ_WDATA_IN,
  input  wire logic [eac_pkg::BYTE_W-1:0]  REQ_BYTES_IN,
  input  wire logic [eac_pkg::CTRL_W-1:0]  ACK_GROUP_CTRL_LOW_IN,
  input  wire logic [eac_pkg::DLY_W-1:0]   OE_ASSERT_DELAY_IN,
  input  wire logic [eac_pkg::DLY_W-1:0]   SELECT_ASSERT_DELAY_IN,
  input  wire logic [eac_pkg::DLY_W-1:0]   WRITE_STROBE_ASSERT_DELAY_IN,
  input  wire logic [eac_pkg::WSC_W-1:0]   WAIT_STATE_COUNT_IN,
  input  wire logic                        ACK_SOURCE_SELECT_IN,
  input  wire logic                        EXT_ACK_N_IN,
  input  wire logic [eac_pkg::DATA_W-1:0]  EXT_RDATA_IN,
  output logic      [eac_pkg::ADDR_W-1:0]  EXT_ADDR_OUT,
  output logic      [7:0]                  CHIP_SEL_N_OUT,
  output logic                             EXT_RW_OUT,
  output logic                             EXT_OE_N_OUT,
  output logic      [eac_pkg::BYTE_W-1:0]  BYTE_STROBE_N_OUT,
  output logic      [eac_pkg::DATA_W-1:0]  EXT_WDATA_OUT,
  output logic                             EXT_WDATA_OE_OUT,
  output logic                             REQ_DONE_OUT,
  output logic                             REQ_ERROR_OUT,
  output logic      [eac_pkg::DATA_W-1:0]  REQ_RDATA_OUT,
  output logic                             BUSY_OUT
);
  import eac_pkg::*;

  eac_state_e             state_q, state_d;
  logic [ADDR_W-1:0]      addr_q, addr_d;
  logic [7:0]             sel_q, sel_d;
  logic                   rw_q, rw_d;
  logic                   oe_q, oe_d;
  logic [BYTE_W-1:0]      bs_q, bs_d;
  logic [DATA_W-1:0]      wd_q, wd_d;
  logic                   wdoe_q, wdoe_d;
  logic                   done_q, done_d;
  logic                   err_q, err_d;
  logic [DATA_W-1:0]      rd_q, rd_d;
  logic                   wr_q, wr_d;
  logic                   ext_q, ext_d;
  logic [GRP_W-1:0]       grp_q, grp_d;
  logic [BYTE_W-1:0]      bytes_q, bytes_d;
  logic [DLY_W-1:0]       elap_q, elap_d;
  logic [WSC_W-1:0]       wcnt_q, wcnt_d;
  logic                   busy_q, busy_d;
  logic                   tmo_start;
  logic                   tmo_run;
  logic                   tmo_expired;
  logic                   ack_seen;
  logic                   read_bs_ok;

  // One-hot active-low select for a group number
  function automatic logic [7:0] group_sel_n(input logic [GRP_W-1:0] g);
    logic [7:0] s;
    s    = SEL_NONE;
    s[g] = 1'b0;
    return s;
  endfunction : group_sel_n

  // Acknowledge only counts when low, and only as an external-ack cycle
  assign ack_seen   = ext_q && (EXT_ACK_N_IN == ACK_ASSERTED);
  assign read_bs_ok = !ACK_GROUP_CTRL_LOW_IN[READ_BYTE_CTL_BIT];
  assign tmo_start  = (state_q == ST_IDLE) && REQ_IN;
  assign tmo_run    = (state_q == ST_WAIT) && ext_q && !ack_seen;

  eac_timeout u_timeout
  (
    .clk_in      (MCLK_IN),
    .rst_n_in    (RST_N_IN),
    .start_in    (tmo_start),
    .run_in      (tmo_run),
    .expired_out (tmo_expired)
  );

  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    sel_d   = sel_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    bs_d    = bs_q;
    wd_d    = wd_q;
    wdoe_d  = wdoe_q;
    done_d  = 1'b0;
    err_d   = 1'b0;
    rd_d    = rd_q;
    wr_d    = wr_q;
    ext_d   = ext_q;
    grp_d   = grp_q;
    bytes_d = bytes_q;
    elap_d  = elap_q;
    wcnt_d  = wcnt_q;
    case (state_q)
      ST_IDLE:
      begin
        if (REQ_IN)
        begin
          addr_d  = REQ_ADDR_IN;
          wr_d    = REQ_WRITE_IN;
          grp_d   = REQ_GROUP_IN;
          bytes_d = REQ_BYTES_IN;
          wd_d    = REQ_WDATA_IN;
          elap_d  = DLY_ZERO;
          wcnt_d  = WAIT_STATE_COUNT_IN;
          // External ack only for the ack group with ack-mode wait count
          ext_d   = (REQ_GROUP_IN == ACK_GROUP) && !ACK_SOURCE_SELECT_IN
                    && (WAIT_STATE_COUNT_IN == WSC_EXT_ACK);
          rw_d    = REQ_WRITE_IN ? RW_WRITE : RW_READ;
          wdoe_d  = REQ_WRITE_IN;
          // Reads select at once; writes may hold off select
          if (!REQ_WRITE_IN || (SELECT_ASSERT_DELAY_IN == DLY_ZERO))
          begin
            sel_d = group_sel_n(REQ_GROUP_IN);
          end
          state_d = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (elap_q != {DLY_W{1'b1}})
        begin
          elap_d = elap_q + 1'b1;
        end
        if (wr_q && (elap_d >= SELECT_ASSERT_DELAY_IN))
        begin
          sel_d = group_sel_n(grp_q);
        end
        if (wr_q && (elap_d >= WRITE_STROBE_ASSERT_DELAY_IN))
        begin
          bs_d = ~bytes_q;
        end
        if (!wr_q && (elap_d >= OE_ASSERT_DELAY_IN))
        begin
          oe_d = 1'b0;
          if (read_bs_ok)
          begin
            bs_d = ~bytes_q;
          end
        end
        if (ext_q)
        begin
          if (ack_seen)
          begin
            rd_d    = EXT_RDATA_IN;
            done_d  = 1'b1;
            state_d = ST_DONE;
          end
          else if (tmo_expired)
          begin
            err_d   = 1'b1;
            state_d = ST_DONE;
          end
        end
        else if (wcnt_q <= WSC_ONE)
        begin
          rd_d    = EXT_RDATA_IN;
          done_d  = 1'b1;
          state_d = ST_DONE;
        end
        else
        begin
          wcnt_d = wcnt_q - WSC_ONE;
        end
      end
      ST_DONE:
      begin
        sel_d   = SEL_NONE;
        rw_d    = RW_READ;
        oe_d    = 1'b1;
        bs_d    = {BYTE_W{1'b1}};
        wdoe_d  = 1'b0;
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    // Busy follows the next state so it rises on the taking edge
    busy_d = (state_d != ST_IDLE);
  end

  // Every bus control launches from the system clock edge
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      state_q <= ST_IDLE;
      addr_q  <= '0;
      sel_q   <= SEL_NONE;
      rw_q    <= RW_READ;
      oe_q    <= 1'b1;
      bs_q    <= {BYTE_W{1'b1}};
      wd_q    <= '0;
      wdoe_q  <= 1'b0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      rd_q    <= '0;
      wr_q    <= 1'b0;
      ext_q   <= 1'b0;
      grp_q   <= '0;
      bytes_q <= '0;
      elap_q  <= DLY_ZERO;
      wcnt_q  <= '0;
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      sel_q   <= sel_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      bs_q    <= bs_d;
      wd_q    <= wd_d;
      wdoe_q  <= wdoe_d;
      done_q  <= done_d;
      err_q   <= err_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      ext_q   <= ext_d;
      grp_q   <= grp_d;
      bytes_q <= bytes_d;
      elap_q  <= elap_d;
      wcnt_q  <= wcnt_d;
      busy_q  <= busy_d;
    end
  end

  assign EXT_ADDR_OUT      = addr_q;
  assign CHIP_SEL_N_OUT    = sel_q;
  assign EXT_RW_OUT        = rw_q;
  assign EXT_OE_N_OUT      = oe_q;
  assign BYTE_STROBE_N_OUT = bs_q;
  assign EXT_WDATA_OUT     = wd_q;
  assign EXT_WDATA_OE_OUT  = wdoe_q;
  assign REQ_DONE_OUT      = done_q;
  assign REQ_ERROR_OUT     = err_q;
  assign REQ_RDATA_OUT     = rd_q;
  assign BUSY_OUT          = busy_q;
endmodule : eac_cycle_ctrl

// ### rtl/eac_pkg.sv
// Package for the acknowledge-terminated external bus cycle controller.
// Assumes one system bus clock; all configuration arrives as plain ports.
package eac_pkg;
  localparam int unsigned         ADDR_W           = 24;
  localparam int unsigned         DATA_W           = 16;
  localparam int unsigned         BYTE_W           = 2;
  localparam int unsigned         GRP_W            = 3;
  localparam int unsigned         DLY_W            = 4;
  localparam int unsigned         WSC_W            = 6;
  localparam int unsigned         CTRL_W           = 16;
  localparam int unsigned         TMO_W            = 10;
  // Acknowledge group number and timeout count
  localparam logic [GRP_W-1:0]    ACK_GROUP        = 3'h5;
  localparam logic [TMO_W-1:0]    TIMEOUT_COUNT    = 10'h3fe;
  // Wait-state count value that hands termination to the external acknowledge
  localparam logic [WSC_W-1:0]    WSC_EXT_ACK      = 6'h3f;
  localparam int unsigned         READ_BYTE_CTL_BIT = 11;
  localparam logic                ACK_ASSERTED     = 1'b0;
  localparam logic                RW_WRITE         = 1'b0;
  localparam logic                RW_READ          = 1'b1;
  localparam logic [DLY_W-1:0]    DLY_ZERO         = 4'h0;
  localparam logic [TMO_W-1:0]    TMO_ZERO         = 10'h000;
  localparam logic [TMO_W-1:0]    TMO_ONE          = 10'h001;
  localparam logic [WSC_W-1:0]    WSC_ONE          = 6'h01;
  localparam logic [7:0]          SEL_NONE         = 8'hff;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } eac_state_e;
endpackage : eac_pkg

// ### rtl/eac_timeout.sv
// Bus timeout monitor: counts clocks while an acknowledge-terminated cycle waits.
// Assumes start is a one-cycle pulse and run is held while the cycle waits.
`timescale 1ns/1ps
module eac_timeout
  import eac_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  input  wire logic run_in,
  output logic      expired_out
);
  logic [TMO_W-1:0] cnt_q;
  logic [TMO_W-1:0] cnt_d;
  logic             exp_q;
  logic             exp_d;

  always_comb
  begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (start_in)
    begin
      cnt_d = TMO_ZERO;
    end
    else if (run_in && !exp_q)
    begin
      cnt_d = cnt_q + TMO_ONE;
      exp_d = (cnt_d == TIMEOUT_COUNT);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_q <= TMO_ZERO;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_out = exp_q;
endmodule : eac_timeout

// ### test/eac_ack_partner.sv
// Far-side memory: acknowledges a selected cycle after lat_in clocks.
// Assumes lat_in of zero means it never answers; the line has a pull-up.
`timescale 1ns/1ps
module eac_ack_partner
(
  input  wire logic        clk_in,
  input  wire logic        sel_n_in,
  input  wire logic [10:0] lat_in,
  input  wire logic [15:0] data_in,
  output logic             ack_n_out,
  output logic [15:0]      rdata_out
);
  int n = 0;
  initial
  begin
    ack_n_out = 1'b1;
    rdata_out = 16'h0000;
    forever
    begin
      @(posedge clk_in);
      #1;
      n = sel_n_in ? 0 : n + 1;
      ack_n_out = !(lat_in != 11'h000 && n >= int'(lat_in));
      // Released data toggles so a stale value is never taken for a good one
      rdata_out = ack_n_out ? ~rdata_out : data_in;
    end
  end
endmodule : eac_ack_partner

// ### test/eac_cycle_asserts.sv
// Port checker for the acknowledge cycle controller.
// Assumes configuration inputs stay stable while a cycle runs.
`timescale 1ns/1ps
module eac_cycle_asserts
  import eac_pkg::*;
(
  input wire logic        MCLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        REQ_IN,
  input wire logic        REQ_WRITE_IN,
  input wire logic [2:0]  REQ_GROUP_IN,
  input wire logic [23:0] REQ_ADDR_IN,
  input wire logic [15:0] REQ_WDATA_IN,
  input wire logic [1:0]  REQ_BYTES_IN,
  input wire logic [15:0] ACK_GROUP_CTRL_LOW_IN,
  input wire logic [3:0]  OE_ASSERT_DELAY_IN,
  input wire logic [3:0]  SELECT_ASSERT_DELAY_IN,
  input wire logic [5:0]  WAIT_STATE_COUNT_IN,
  input wire logic        ACK_SOURCE_SELECT_IN,
  input wire logic        EXT_ACK_N_IN,
  input wire logic [23:0] EXT_ADDR_OUT,
  input wire logic [7:0]  CHIP_SEL_N_OUT,
  input wire logic        EXT_RW_OUT,
  input wire logic        EXT_OE_N_OUT,
  input wire logic [1:0]  BYTE_STROBE_N_OUT,
  input wire logic [15:0] EXT_WDATA_OUT,
  input wire logic        EXT_WDATA_OE_OUT,
  input wire logic        REQ_DONE_OUT,
  input wire logic        REQ_ERROR_OUT,
  input wire logic        BUSY_OUT
);
  // Clocks since the edge that took the request
  logic [10:0] cyc_q;
  logic [10:0] cyc_d;
  logic        take;
  logic        ack_mode;
  assign take = REQ_IN && !BUSY_OUT;
  assign ack_mode = WAIT_STATE_COUNT_IN == WSC_EXT_ACK && !ACK_SOURCE_SELECT_IN;
  always_comb cyc_d = take ? 11'h000 : cyc_q + 11'h001;
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    if (!RST_N_IN) cyc_q <= 11'h000;
    else cyc_q <= cyc_d;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  rd_start_a: assert property (take && !REQ_WRITE_IN |=> EXT_RW_OUT &&
    EXT_ADDR_OUT == $past(REQ_ADDR_IN) && CHIP_SEL_N_OUT == ~(8'h01 << $past(REQ_GROUP_IN))
    && !EXT_WDATA_OE_OUT) else $error("read start wrong");
  wr_start_a: assert property (take && REQ_WRITE_IN |=> !EXT_RW_OUT &&
    EXT_ADDR_OUT == $past(REQ_ADDR_IN)) else $error("write start wrong");
  wr_data_a: assert property (take && REQ_WRITE_IN |=> EXT_WDATA_OE_OUT &&
    EXT_WDATA_OUT == $past(REQ_WDATA_IN)) else $error("write data wrong");
  rd_bs_on_a: assert property ($fell(EXT_OE_N_OUT) &&
    !ACK_GROUP_CTRL_LOW_IN[READ_BYTE_CTL_BIT] |-> BYTE_STROBE_N_OUT == ~REQ_BYTES_IN)
    else $error("read strobe missing");
  ack_done_a: assert property (REQ_DONE_OUT && ack_mode && !CHIP_SEL_N_OUT[ACK_GROUP]
    |-> $past(EXT_ACK_N_IN) == ACK_ASSERTED) else $error("done without ack");
  int_wait_a: assert property (REQ_DONE_OUT && WAIT_STATE_COUNT_IN == WSC_EXT_ACK &&
    !(ack_mode && !CHIP_SEL_N_OUT[ACK_GROUP]) |-> cyc_q == 11'(WSC_EXT_ACK))
    else $error("wait count");
  // Expiry is registered, then the error one edge later
  tmo_err_a: assert property (REQ_ERROR_OUT |->
    cyc_q == 11'(TIMEOUT_COUNT) + 11'h001 && !REQ_DONE_OUT) else $error("timeout count");
  end_seq_a: assert property (REQ_DONE_OUT || REQ_ERROR_OUT |=> CHIP_SEL_N_OUT == SEL_NONE
    && EXT_OE_N_OUT && &BYTE_STROBE_N_OUT ##1 !BUSY_OUT) else $error("cycle end");
  rd_bstrb_a: assert property (BUSY_OUT && EXT_RW_OUT &&
    ACK_GROUP_CTRL_LOW_IN[READ_BYTE_CTL_BIT] |-> &BYTE_STROBE_N_OUT) else $error("read strobe");
  oe_delay_a: assert property ($fell(EXT_OE_N_OUT) && !CHIP_SEL_N_OUT[ACK_GROUP] |-> cyc_q ==
    (OE_ASSERT_DELAY_IN == DLY_ZERO ? 11'd1 : 11'(OE_ASSERT_DELAY_IN))) else $error("oe delay");
  sel_delay_a: assert property ($fell(CHIP_SEL_N_OUT[ACK_GROUP]) && !EXT_RW_OUT |->
    cyc_q == 11'(SELECT_ASSERT_DELAY_IN)) else $error("select delay");
  cover property (REQ_ERROR_OUT);
  cover property (REQ_DONE_OUT && EXT_RW_OUT);
  cover property (REQ_DONE_OUT && !EXT_RW_OUT);
endmodule : eac_cycle_asserts

// ### test/tb_ext_bus_ack_cycle_control.sv
// Testbench for the acknowledge cycle controller with a far-side model.
// Assumes one 125 MHz clock and results checked from an expectation queue.
`timescale 1ns/1ps
module tb_ext_bus_ack_cycle_control;
  import eac_pkg::*;
  logic MCLK_IN = 0, RST_N_IN = 0, REQ_IN = 0, REQ_WRITE_IN = 0, ACK_SOURCE_SELECT_IN = 0;
  logic [2:0] REQ_GROUP_IN = 0;
  logic [23:0] REQ_ADDR_IN = 0, EXT_ADDR_OUT;
  logic [15:0] REQ_WDATA_IN = 0, ACK_GROUP_CTRL_LOW_IN = 0, EXT_RDATA_IN, EXT_WDATA_OUT;
  logic [15:0] REQ_RDATA_OUT, pdata = 0;
  logic [1:0] REQ_BYTES_IN = 1, BYTE_STROBE_N_OUT;
  logic [3:0] OE_ASSERT_DELAY_IN = 0, SELECT_ASSERT_DELAY_IN = 0, WRITE_STROBE_ASSERT_DELAY_IN = 0;
  logic [5:0] WAIT_STATE_COUNT_IN = 6'h3f;
  logic [7:0] CHIP_SEL_N_OUT;
  logic [10:0] lat = 0;
  logic EXT_ACK_N_IN, EXT_RW_OUT, EXT_OE_N_OUT, EXT_WDATA_OE_OUT;
  logic REQ_DONE_OUT, REQ_ERROR_OUT, BUSY_OUT;
  logic [18:0] exp_q[$];
  logic [18:0] e;
  int fail_count = 0, n_checks = 0, tn = 0;
  eac_cycle_ctrl i_eac_cycle_ctrl
  (
    .MCLK_IN                      (MCLK_IN),
    .RST_N_IN                     (RST_N_IN),
    .REQ_IN                       (REQ_IN),
    .REQ_WRITE_IN                 (REQ_WRITE_IN),
    .REQ_GROUP_IN                 (REQ_GROUP_IN),
    .REQ_ADDR_IN                  (REQ_ADDR_IN),
    .REQ_WDATA_IN                 (REQ_WDATA_IN),
    .REQ_BYTES_IN                 (REQ_BYTES_IN),
    .ACK_GROUP_CTRL_LOW_IN        (ACK_GROUP_CTRL_LOW_IN),
    .OE_ASSERT_DELAY_IN           (OE_ASSERT_DELAY_IN),
    .SELECT_ASSERT_DELAY_IN       (SELECT_ASSERT_DELAY_IN),
    .WRITE_STROBE_ASSERT_DELAY_IN (WRITE_STROBE_ASSERT_DELAY_IN),
    .WAIT_STATE_COUNT_IN          (WAIT_STATE_COUNT_IN),
    .ACK_SOURCE_SELECT_IN         (ACK_SOURCE_SELECT_IN),
    .EXT_ACK_N_IN                 (EXT_ACK_N_IN),
    .EXT_RDATA_IN                 (EXT_RDATA_IN),
    .EXT_ADDR_OUT                 (EXT_ADDR_OUT),
    .CHIP_SEL_N_OUT               (CHIP_SEL_N_OUT),
    .EXT_RW_OUT                   (EXT_RW_OUT),
    .EXT_OE_N_OUT                 (EXT_OE_N_OUT),
    .BYTE_STROBE_N_OUT            (BYTE_STROBE_N_OUT),
    .EXT_WDATA_OUT                (EXT_WDATA_OUT),
    .EXT_WDATA_OE_OUT             (EXT_WDATA_OE_OUT),
    .REQ_DONE_OUT                 (REQ_DONE_OUT),
    .REQ_ERROR_OUT                (REQ_ERROR_OUT),
    .REQ_RDATA_OUT                (REQ_RDATA_OUT),
    .BUSY_OUT                     (BUSY_OUT)
  );
  eac_ack_partner i_eac_ack_partner (.clk_in(MCLK_IN), .sel_n_in(&CHIP_SEL_N_OUT), .lat_in(lat),
    .data_in(pdata), .ack_n_out(EXT_ACK_N_IN), .rdata_out(EXT_RDATA_IN));
  initial forever #4 MCLK_IN = ~MCLK_IN;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // Result watcher: {read data checked, done, error, data}
  always @(negedge MCLK_IN)
    if (REQ_DONE_OUT === 1'b1 || REQ_ERROR_OUT === 1'b1)
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 19'h7ffff;
      n_checks++;
      if ({REQ_DONE_OUT, REQ_ERROR_OUT, REQ_RDATA_OUT & {16{e[18]}}} !== e[17:0])
      begin
        fail_count++;
        $display("MISMATCH t=%0t got %h exp %h", $time, {REQ_DONE_OUT, REQ_ERROR_OUT,
          REQ_RDATA_OUT & {16{e[18]}}}, e[17:0]);
      end
    end
  task automatic run(input logic wr, input logic [2:0] g, input logic [10:0] l,
    input logic [5:0] w, input logic asel, input logic b11);
    logic err;
    err = g == ACK_GROUP && w == WSC_EXT_ACK && !asel && l == 11'h000;
    @(posedge MCLK_IN);
    #1;
    {REQ_WRITE_IN, REQ_GROUP_IN, lat, WAIT_STATE_COUNT_IN, ACK_SOURCE_SELECT_IN} = {wr, g, l, w, asel};
    {REQ_ADDR_IN, REQ_WDATA_IN, pdata} = 56'({$urandom, $urandom});
    {OE_ASSERT_DELAY_IN, SELECT_ASSERT_DELAY_IN, WRITE_STROBE_ASSERT_DELAY_IN} = 12'($urandom);
    REQ_BYTES_IN = 2'($urandom_range(1, 3));
    ACK_GROUP_CTRL_LOW_IN = (16'($urandom) & 16'hf7ff) | {4'h0, b11, 11'h000};
    REQ_IN = 1'b1;
    // Data is only compared on successful reads, so it is masked on both sides
    exp_q.push_back({!wr && !err, !err, err, pdata & {16{!wr && !err}}});
    @(posedge MCLK_IN);
    #1;
    REQ_IN = 1'b0;
    while (BUSY_OUT !== 1'b0) @(negedge MCLK_IN);
    $display("test %0d done", tn);
    tn++;
  endtask : run
  initial
  begin
    void'($urandom(32'h17b57657));
    repeat (2) @(posedge MCLK_IN);
    #1 RST_N_IN = 1'b1;
    run(1'b0, 3'h5, 11'd3, 6'h3f, 1'b0, 1'b0);
    run(1'b0, 3'h5, 11'd2, 6'h3f, 1'b0, 1'b1);
    run(1'b1, 3'h5, 11'd5, 6'h3f, 1'b0, 1'b0);
    run(1'b0, 3'h5, 11'd0, 6'h3f, 1'b0, 1'b0);
    run(1'b1, 3'h2, 11'd1, 6'h3f, 1'b0, 1'b0);
    run(1'b0, 3'h5, 11'd1, 6'h3f, 1'b1, 1'b0);
    run(1'b0, 3'h5, 11'd1, 6'h03, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      run(1'($urandom), 3'h5, 11'($urandom_range(1, 20)), 6'h3f, 1'b0, 1'($urandom));
    finish_test();
  end
  initial
  begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule : tb_ext_bus_ack_cycle_control
bind eac_cycle_ctrl eac_cycle_asserts i_eac_cycle_asserts
(
  .MCLK_IN                (MCLK_IN),
  .RST_N_IN               (RST_N_IN),
  .REQ_IN                 (REQ_IN),
  .REQ_WRITE_IN           (REQ_WRITE_IN),
  .REQ_GROUP_IN           (REQ_GROUP_IN),
  .REQ_ADDR_IN            (REQ_ADDR_IN),
  .REQ_WDATA_IN           (REQ_WDATA_IN),
  .REQ_BYTES_IN           (REQ_BYTES_IN),
  .ACK_GROUP_CTRL_LOW_IN  (ACK_GROUP_CTRL_LOW_IN),
  .OE_ASSERT_DELAY_IN     (OE_ASSERT_DELAY_IN),
  .SELECT_ASSERT_DELAY_IN (SELECT_ASSERT_DELAY_IN),
  .WAIT_STATE_COUNT_IN    (WAIT_STATE_COUNT_IN),
  .ACK_SOURCE_SELECT_IN   (ACK_SOURCE_SELECT_IN),
  .EXT_ACK_N_IN           (EXT_ACK_N_IN),
  .EXT_ADDR_OUT           (EXT_ADDR_OUT),
  .CHIP_SEL_N_OUT         (CHIP_SEL_N_OUT),
  .EXT_RW_OUT             (EXT_RW_OUT),
  .EXT_OE_N_OUT           (EXT_OE_N_OUT),
  .BYTE_STROBE_N_OUT      (BYTE_STROBE_N_OUT),
  .EXT_WDATA_OUT          (EXT_WDATA_OUT),
  .EXT_WDATA_OE_OUT       (EXT_WDATA_OE_OUT),
  .REQ_DONE_OUT           (REQ_DONE_OUT),
  .REQ_ERROR_OUT          (REQ_ERROR_OUT),
  .BUSY_OUT               (BUSY_OUT)
);
